// ===== core/mpc_pkg.sv
// Package for the multi-port pin configuration block: widths, reset values, structs.
// Assumes a single core clock domain and plain ports for all control bits.
package mpc_pkg;

    // ****************************************************************
    // Port widths
    // ****************************************************************
    localparam int ANA_CAP_W   = 4;
    localparam int FIX_OUT_W   = 8;
    localparam int ANA_ONLY_W  = 3;
    localparam int BIDIR_W     = 8;
    localparam int FIX_IN_W    = 8;

    // ****************************************************************
    // Reset values and special bit positions
    // ****************************************************************
    localparam logic [BIDIR_W-1:0]   BIDIR_DIR_RST  = 8'h00;
    localparam logic [BIDIR_W-1:0]   BIDIR_DATA_RST = 8'h00;
    localparam logic [FIX_OUT_W-1:0] FIX_OUT_RST    = 8'h00;
    localparam logic [ANA_CAP_W-1:0] ANA_DIG_RST    = 4'h0;
    localparam logic [1:0]           SYNC_RST       = 2'h0;
    localparam int PWM1_BIT      = 1;
    localparam int PWM2_BIT      = 2;
    localparam int I2C_SCL_BIT   = 3;
    localparam int I2C_SDA_BIT   = 4;
    localparam int IR_BIT        = 0;
    localparam int KB_CLK_BIT    = 6;
    localparam int KB_DATA_BIT   = 7;
    localparam int REFRESH_PER_NS = 1000;
    localparam int CLK_PER_NS     = 5;
    localparam int REFRESH_CYC    = REFRESH_PER_NS / CLK_PER_NS;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic                 wr;
        logic [BIDIR_W-1:0]   val;
    } mpc_wr_s;

    typedef struct packed {
        logic                 set_hi;
        logic                 set_lo;
        logic [2:0]           idx;
    } mpc_pin_op_s;

    typedef struct packed {
        logic                 ir;
        logic                 kb_clk;
        logic                 kb_data;
    } mpc_special_s;

endpackage

// ===== core/mpc_top.sv
// Pin configuration logic: analog-capable, fixed output, analog-only,
// bidirectional and fixed input ports. Control arrives on plain ports,
// pins are treated as asynchronous raw levels; digital reads are synchronised here, the analogue outputs pass the raw pins.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Four analog pins, readable as digital
// - Eight fixed outputs, direction never changes
// - Three analog-only pins, no digital path
// - Bidirectional pins reset as inputs, per-pin output
// - Fixed-input port unqualified; bidir needs select
// - Direction mask: 1 output, 0 input
// - Tristate mask inverted: 1 input, 0 output
// - Tristate register periodically refreshed from setting
// - Data write drives output-configured pins
// - Single-pin set makes output and drives level
// - Bits 1,2 PWM; bits 3,4 I2C
// - Fixed-input bits 0,6,7 feed IR, keyboard
// - Analog-capable digital use: level sampling only
module mpc_top (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         ce,
    // Fixed output port
    input  wire mpc_pkg::mpc_wr_s             fix_out_wr,
    output logic [mpc_pkg::FIX_OUT_W-1:0]     fixed_output_port_o,
    // Analog-capable port
    input  wire logic [mpc_pkg::ANA_CAP_W-1:0]  ana_cap_pin_i,
    output logic [mpc_pkg::ANA_CAP_W-1:0]     ana_cap_level,
    output logic [mpc_pkg::ANA_CAP_W-1:0]     ana_cap_adc,
    // Analog-only port
    input  wire logic [mpc_pkg::ANA_ONLY_W-1:0] analog_only_port_i,
    output logic [mpc_pkg::ANA_ONLY_W-1:0]    analog_only_adc,
    // Bidirectional port control
    input  wire mpc_pkg::mpc_wr_s             dir_wr,
    input  wire mpc_pkg::mpc_wr_s             tris_wr,
    input  wire mpc_pkg::mpc_wr_s             tris_raw_wr,
    input  wire mpc_pkg::mpc_wr_s             bidir_data_wr,
    input  wire mpc_pkg::mpc_pin_op_s         pin_op,
    input  wire logic                         pwm_en,
    input  wire logic                         i2c_target_enable_cmd,
    input  wire logic [1:0]                   pwm_i,
    input  wire logic                         i2c_scl_oe_i,
    input  wire logic                         i2c_sda_oe_i,
    // Bidirectional pins
    input  wire logic [mpc_pkg::BIDIR_W-1:0]  bidir_pin_i,
    output logic [mpc_pkg::BIDIR_W-1:0]       bidir_pin_o,
    output logic [mpc_pkg::BIDIR_W-1:0]       bidir_pin_oe,
    output logic [mpc_pkg::BIDIR_W-1:0]       bidir_dir,
    output logic [mpc_pkg::BIDIR_W-1:0]       bidir_tris_hw,
    output logic                              i2c_scl_in,
    output logic                              i2c_sda_in,
    // Input reads
    input  wire logic                         rd_sel_bidir,
    output logic [mpc_pkg::FIX_IN_W-1:0]      rd_data,
    // Fixed input port
    input  wire logic [mpc_pkg::FIX_IN_W-1:0] fixed_input_port_i,
    output mpc_pkg::mpc_special_s             special_in
);
    import mpc_pkg::*;

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    logic [FIX_IN_W-1:0]  fin_s1_r, fin_s2_r, fin_s1_nxt, fin_s2_nxt;
    logic [BIDIR_W-1:0]   bin_s1_r, bin_s2_r, bin_s1_nxt, bin_s2_nxt;
    logic [ANA_CAP_W-1:0] ain_s1_r, ain_s2_r, ain_s1_nxt, ain_s2_nxt;

    always_comb begin
        fin_s1_nxt = fixed_input_port_i;
        fin_s2_nxt = fin_s1_r;
        bin_s1_nxt = bidir_pin_i;
        bin_s2_nxt = bin_s1_r;
        ain_s1_nxt = ana_cap_pin_i;
        ain_s2_nxt = ain_s1_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fin_s1_r <= '0;
            fin_s2_r <= '0;
            bin_s1_r <= '0;
            bin_s2_r <= '0;
            ain_s1_r <= '0;
            ain_s2_r <= '0;
        end else if (ce) begin
            fin_s1_r <= fin_s1_nxt;
            fin_s2_r <= fin_s2_nxt;
            bin_s1_r <= bin_s1_nxt;
            bin_s2_r <= bin_s2_nxt;
            ain_s1_r <= ain_s1_nxt;
            ain_s2_r <= ain_s2_nxt;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [BIDIR_W-1:0]   dir_r, dir_nxt;
    logic [BIDIR_W-1:0]   data_r, data_nxt;
    logic [BIDIR_W-1:0]   tris_hw_r, tris_hw_nxt;
    logic [FIX_OUT_W-1:0] fout_r, fout_nxt;
    logic [7:0]           refresh_cnt_r, refresh_cnt_nxt;

    always_comb begin
        dir_nxt         = dir_r;
        data_nxt        = data_r;
        fout_nxt        = fout_r;
        tris_hw_nxt     = tris_hw_r;
        refresh_cnt_nxt = refresh_cnt_r + 8'h01;
        if (fix_out_wr.wr) begin
            fout_nxt = fix_out_wr.val;
        end
        if (dir_wr.wr) begin
            dir_nxt = dir_wr.val;
        end else if (tris_wr.wr) begin
            dir_nxt = ~tris_wr.val;
        end
        if (bidir_data_wr.wr) begin
            data_nxt = bidir_data_wr.val;
        end
        if (pin_op.set_hi || pin_op.set_lo) begin
            dir_nxt[pin_op.idx]  = 1'b1;
            data_nxt[pin_op.idx] = pin_op.set_hi;
        end
        // Raw pokes land briefly, then the stored setting wins again
        if (refresh_cnt_r == 8'(REFRESH_CYC - 1)) begin
            refresh_cnt_nxt = 8'h00;
            tris_hw_nxt     = ~dir_nxt;
        end else if (tris_raw_wr.wr) begin
            tris_hw_nxt = tris_raw_wr.val;
        end else if (dir_wr.wr || tris_wr.wr || pin_op.set_hi || pin_op.set_lo) begin
            tris_hw_nxt = ~dir_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dir_r         <= BIDIR_DIR_RST;
            data_r        <= BIDIR_DATA_RST;
            fout_r        <= FIX_OUT_RST;
            tris_hw_r     <= ~BIDIR_DIR_RST;
            refresh_cnt_r <= 8'h00;
        end else if (ce) begin
            dir_r         <= dir_nxt;
            data_r        <= data_nxt;
            fout_r        <= fout_nxt;
            tris_hw_r     <= tris_hw_nxt;
            refresh_cnt_r <= refresh_cnt_nxt;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    always_comb begin
        // Pin drive follows the hardware tristate register
        bidir_pin_oe = ~tris_hw_r;
        bidir_pin_o  = data_r;
        if (pwm_en) begin
            bidir_pin_oe[PWM1_BIT] = 1'b1;
            bidir_pin_oe[PWM2_BIT] = 1'b1;
            bidir_pin_o[PWM1_BIT]  = pwm_i[0];
            bidir_pin_o[PWM2_BIT]  = pwm_i[1];
        end
        if (i2c_target_enable_cmd) begin
            // Open drain: drive low only
            bidir_pin_oe[I2C_SCL_BIT] = i2c_scl_oe_i;
            bidir_pin_oe[I2C_SDA_BIT] = i2c_sda_oe_i;
            bidir_pin_o[I2C_SCL_BIT]  = 1'b0;
            bidir_pin_o[I2C_SDA_BIT]  = 1'b0;
        end
    end

    assign i2c_scl_in          = bin_s2_r[I2C_SCL_BIT];
    assign i2c_sda_in          = bin_s2_r[I2C_SDA_BIT];
    assign bidir_dir           = dir_r;
    assign bidir_tris_hw       = tris_hw_r;
    assign fixed_output_port_o = fout_r;

    // ****************************************************************
    // Inputs and analogue routing
    // ****************************************************************
    // Fixed-input port is the default; bidir port only when selected
    assign rd_data = rd_sel_bidir ? bin_s2_r : fin_s2_r;

    assign special_in.ir      = fin_s2_r[IR_BIT];
    assign special_in.kb_clk  = fin_s2_r[KB_CLK_BIT];
    assign special_in.kb_data = fin_s2_r[KB_DATA_BIT];

    // Level only: no edge counting or pulse timing on these pins
    assign ana_cap_level   = ain_s2_r;
    assign ana_cap_adc     = ana_cap_pin_i;
    assign analog_only_adc = analog_only_port_i;

endmodule

`default_nettype wire

// ===== sim/mpc_chk.sv
// Port-level assertions for the pin configuration block.
// Assumes the single core clock and an async active-high reset.
`timescale 1ns/100ps
`default_nettype none
module mpc_chk (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 ce,
    input wire mpc_pkg::mpc_wr_s     fix_out_wr,
    input wire mpc_pkg::mpc_wr_s     dir_wr,
    input wire mpc_pkg::mpc_wr_s     tris_wr,
    input wire mpc_pkg::mpc_wr_s     tris_raw_wr,
    input wire mpc_pkg::mpc_pin_op_s pin_op,
    input wire logic                 pwm_en,
    input wire logic                 i2c_target_enable_cmd,
    input wire logic [7:0]           fixed_output_port_o,
    input wire logic [7:0]           bidir_dir,
    input wire logic [7:0]           bidir_tris_hw,
    input wire logic [7:0]           bidir_pin_oe,
    input wire logic [7:0]           bidir_pin_o,
    input wire logic [3:0]           ana_cap_pin_i,
    input wire logic [3:0]           ana_cap_adc,
    input wire logic [2:0]           analog_only_port_i,
    input wire logic [2:0]           analog_only_adc,
    input wire logic [7:0]           fixed_input_port_i,
    input wire logic                 rd_sel_bidir,
    input wire logic [7:0]           rd_data,
    input wire mpc_pkg::mpc_special_s special_in
);
    import mpc_pkg::*;
    logic [1:0] up_r;
    logic       op_c;
    // Synchroniser output only meaningful after two enabled edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) up_r <= 2'h0;
        else up_r <= {up_r[0], ce};
    end
    assign op_c = pin_op.set_hi | pin_op.set_lo;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_FIX_OUT: assert property (ce && fix_out_wr.wr |=> fixed_output_port_o == $past(fix_out_wr.val))
        else $error("fixed output not stored");
    AST_DIR_SET: assert property (ce && dir_wr.wr && !op_c |=> bidir_dir == $past(dir_wr.val))
        else $error("direction write lost");
    AST_TRIS_INV: assert property (ce && tris_wr.wr && !dir_wr.wr && !op_c |=> bidir_dir == ~$past(tris_wr.val))
        else $error("tristate mask not inverted");
    AST_OE_DIR: assert property (!pwm_en && !i2c_target_enable_cmd |-> bidir_pin_oe == ~bidir_tris_hw)
        else $error("enable differs from tristate");
    AST_PIN_OP: assert property (ce && op_c && !pwm_en && !i2c_target_enable_cmd
        |=> bidir_dir[$past(pin_op.idx)] && bidir_pin_o[$past(pin_op.idx)] == $past(pin_op.set_hi))
        else $error("single pin op wrong");
    AST_REFRESH: assert property (ce && tris_raw_wr.wr |-> ##[1:201] bidir_tris_hw == ~bidir_dir)
        else $error("tristate not refreshed");
    AST_ANALOG: assert property (ana_cap_adc == ana_cap_pin_i && analog_only_adc == analog_only_port_i)
        else $error("analog path broken");
    AST_SYNC: assert property (&up_r && !rd_sel_bidir |-> rd_data == $past(fixed_input_port_i, 2))
        else $error("input read latency wrong");
    AST_SPECIAL: assert property (&up_r |-> special_in == {$past(fixed_input_port_i[0], 2),
        $past(fixed_input_port_i[6], 2), $past(fixed_input_port_i[7], 2)})
        else $error("special inputs wrong");
endmodule
bind mpc_top mpc_chk chk_u (.*);
`default_nettype wire

// ===== sim/mpc_pin_env.sv
// External switches and loads on the bidirectional pins.
// Assumes bit i of every vector is pin i; no pull resistors on the pins.
`timescale 1ns/100ps
`default_nettype none
module mpc_pin_env (
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] sw,
    output logic      [7:0] pin_i
);
    // Driven bits win over the switch level
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & sw);
endmodule
`default_nettype wire

// ===== sim/multi_port_pin_config_tb.sv
// Self-checking bench for the pin configuration block.
// Assumes the design package is compiled first; inputs change at falling edges.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module multi_port_pin_config_tb;
    import mpc_pkg::*;
    logic clk = 0, reset = 1, ce = 1, pwm_en = 0, i2c_target_enable_cmd = 0;
    logic i2c_scl_oe_i = 0, i2c_sda_oe_i = 0, rd_sel_bidir = 0, i2c_scl_in, i2c_sda_in;
    mpc_wr_s fix_out_wr = '0, dir_wr = '0, tris_wr = '0, tris_raw_wr = '0, bidir_data_wr = '0;
    mpc_pin_op_s pin_op = '0;
    mpc_special_s special_in;
    logic [1:0] pwm_i = '0;
    logic [7:0] fixed_output_port_o, bidir_pin_i, bidir_pin_o, bidir_pin_oe, bidir_dir, bidir_tris_hw, rd_data;
    logic [7:0] fixed_input_port_i = '0, sw = '0;
    logic [3:0] ana_cap_pin_i = '0, ana_cap_level, ana_cap_adc;
    logic [2:0] analog_only_port_i = '0, analog_only_adc;
    int fails = 0, n_compared = 0;
    mpc_top dut_u (.*);
    mpc_pin_env env_u (.pin_o(bidir_pin_o), .pin_oe(bidir_pin_oe), .sw(sw), .pin_i(bidir_pin_i));
    initial forever #2.5 clk = ~clk;
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************************************************************
    // Access tasks, entered and left at a falling edge
    // ****************************************************************
    task automatic wr(input int k, input logic [7:0] v);
        case (k)
            0: fix_out_wr = '{1'b1, v};
            1: dir_wr = '{1'b1, v};
            2: tris_wr = '{1'b1, v};
            3: tris_raw_wr = '{1'b1, v};
            default: bidir_data_wr = '{1'b1, v};
        endcase
        @(negedge clk);
        {fix_out_wr.wr, dir_wr.wr, tris_wr.wr, tris_raw_wr.wr, bidir_data_wr.wr} = 5'h00;
    endtask
    task automatic pop(input logic hi, input logic [2:0] idx);
        pin_op = '{hi, !hi, idx};
        @(negedge clk);
        pin_op = '0;
    endtask
    initial begin
        #20us;
        fails++;
        stop_test();
    end
    initial begin
        repeat (5) @(negedge clk);
        reset = 0;
        `CHK(bidir_dir, 8'h00)
        `CHK(bidir_tris_hw, 8'hFF)
        `CHK(bidir_pin_oe, 8'h00)
        wr(0, 8'hA5);
        `CHK(fixed_output_port_o, 8'hA5)
        wr(1, 8'hFF);
        `CHK(bidir_pin_oe, 8'hFF)
        `CHK(bidir_tris_hw, 8'h00)
        wr(2, 8'h0F);
        `CHK(bidir_dir, 8'hF0)
        wr(4, 8'h5A);
        `CHK(bidir_pin_o & bidir_pin_oe, 8'h50)
        pop(1, 3'h2);
        pop(0, 3'h6);
        `CHK(bidir_dir, 8'hF4)
        `CHK(bidir_pin_o & bidir_pin_oe, 8'h14)
        $display("test writes done");
        wr(3, 8'hFF);
        repeat (201) @(negedge clk);
        `CHK(bidir_tris_hw, 8'h0B)
        ce = 0;
        wr(0, 8'h3C);
        `CHK(fixed_output_port_o, 8'hA5)
        ce = 1;
        wr(1, 8'h00);
        sw = 8'h3C;
        fixed_input_port_i = 8'h81;
        ana_cap_pin_i = 4'h9;
        analog_only_port_i = 3'h5;
        @(negedge clk);
        `CHK(rd_data, 8'h00)
        @(negedge clk);
        `CHK(rd_data, 8'h81)
        `CHK(special_in, 3'b101)
        `CHK(ana_cap_level, 4'h9)
        `CHK(analog_only_adc, 3'h5)
        rd_sel_bidir = 1;
        #1;
        `CHK(rd_data, 8'h3C)
        `CHK({i2c_sda_in, i2c_scl_in}, 2'b11)
        $display("test inputs done");
        @(negedge clk);
        {pwm_en, i2c_target_enable_cmd, i2c_scl_oe_i, pwm_i} = 5'h1E;
        #1;
        `CHK(bidir_pin_oe[4:1], 4'b0111)
        `CHK(bidir_pin_o[3:1], 3'b010)
        $display("test special done");
        stop_test();
    end
endmodule
`default_nettype wire
